// ### bench/jbp_core_properties.sv
// Purpose: port-level checks of the jump block
// Assumes: single clock, synchronous active-low reset
// Notes:   pc, mode bit, fetch address, jump-taken bit and flags only; operand decoding is left to the bench
`timescale 1ns/1ps
`default_nettype none
module jbp_core_checker (
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic [7:0]  FLAGS_I,
  input  wire logic [23:0] PC_O,
  input  wire logic [23:0] FETCH_ADDR_O,
  input  wire logic        WIDE_MODE_O,
  input  wire logic        JUMP_TAKEN_O,
  input  wire logic [7:0]  FLAGS_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////
  property p_flags_kept;
    $past(RST_N_I) |-> FLAGS_O == $past(FLAGS_I);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags output altered");
  property p_mode_by_jump;
    $changed(WIDE_MODE_O) |-> JUMP_TAKEN_O;
  endproperty
  a_mode_by_jump: assert property (p_mode_by_jump)
    else $error("mode bit changed without a jump");
  property p_compat_fetch;
    !WIDE_MODE_O |-> FETCH_ADDR_O[15:0] == PC_O[15:0];
  endproperty
  a_compat_fetch: assert property (p_compat_fetch)
    else $error("compat fetch address low half differs from pc");
  property p_compat_pc_hi;
    !WIDE_MODE_O |-> PC_O[23:16] == 8'h00;
  endproperty
  a_compat_pc_hi: assert property (p_compat_pc_hi)
    else $error("compat pc upper byte not zero");
  property p_wide_fetch;
    WIDE_MODE_O |-> FETCH_ADDR_O == PC_O;
  endproperty
  a_wide_fetch: assert property (p_wide_fetch)
    else $error("wide fetch address differs from pc");
  property p_compat_step;
    INSTR_VALID_I && !WIDE_MODE_O |=> JUMP_TAKEN_O || PC_O[15:0] == $past(PC_O[15:0]) + 16'h1;
  endproperty
  a_compat_step: assert property (p_compat_step)
    else $error("compat pc did not step by one");
  property p_wide_step;
    INSTR_VALID_I && WIDE_MODE_O |=> JUMP_TAKEN_O || PC_O == $past(PC_O) + 24'h1;
  endproperty
  a_wide_step: assert property (p_wide_step)
    else $error("wide pc did not step by one");
  property p_idle_hold;
    !INSTR_VALID_I |=> $stable(PC_O) && $stable(WIDE_MODE_O) && !JUMP_TAKEN_O;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("pc moved without a fetched byte");
endmodule
bind jbp_core jbp_core_checker u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .INSTR_VALID_I(INSTR_VALID_I),
  .FLAGS_I(FLAGS_I), .PC_O(PC_O), .FETCH_ADDR_O(FETCH_ADDR_O), .WIDE_MODE_O(WIDE_MODE_O),
  .JUMP_TAKEN_O(JUMP_TAKEN_O), .FLAGS_O(FLAGS_O));
`default_nettype wire

// ### bench/jbp_core_tb.sv
// Purpose: self-checking bench for the jump block
// Assumes: expected pc tracked here from the fed bytes
// Notes:   register inputs held steady while a jump runs
`timescale 1ns/1ps
`default_nettype none
module jbp_core_tb;
  logic        mclk;
  logic        rst_n;
  logic        valid;
  logic [7:0]  ibyte;
  logic [23:0] ptr, idx_x, idx_y, pc, fetch, cur;
  logic [7:0]  page, flags, flags_out;
  logic        wide, taken, illegal;
  int          n_fail = 0;
  int          samples_checked = 0;
  jbp_fetch_model fm (.clk_i(mclk), .valid_o(valid), .byte_o(ibyte));
  jbp_core uut (.MCLK_I(mclk), .RST_N_I(rst_n), .INSTR_VALID_I(valid), .INSTR_BYTE_I(ibyte),
    .PTR_PAIR_I(ptr), .INDEX_X_I(idx_x), .INDEX_Y_I(idx_y), .MEM_BASE_PAGE_I(page), .FLAGS_I(flags),
    .PC_O(pc), .FETCH_ADDR_O(fetch), .WIDE_MODE_O(wide), .JUMP_TAKEN_O(taken),
    .ILLEGAL_SFX_O(illegal), .FLAGS_O(flags_out));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input logic [7:0] b[$]);
    foreach (b[i]) fm.send(b[i]);
    fm.rest();
    #1;
  endtask
  task automatic expect_jump(input logic [23:0] exp_pc, input logic exp_wide, input logic exp_taken);
    check("pc", pc, exp_pc);
    check("wide", {23'h0, wide}, {23'h0, exp_wide});
    check("taken", {23'h0, taken}, {23'h0, exp_taken});
    check("illegal", {23'h0, illegal}, 24'h0);
    check("fetch", fetch, exp_wide ? exp_pc : {page, exp_pc[15:0]});
    check("flags", {16'h0, flags_out}, {16'h0, flags});
    cur = exp_pc;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_absolute();
    run('{8'hc3, 8'h34, 8'h12});
    expect_jump(24'h001234, 1'b0, 1'b1);
    run('{8'h40, 8'hc3, 8'h78, 8'h56});
    expect_jump(24'h005678, 1'b0, 1'b1);
    run('{8'h5b, 8'hc3, 8'hbc, 8'h9a, 8'h7e});
    expect_jump(24'h7e9abc, 1'b1, 1'b1);
    run('{8'hc3, 8'h11, 8'h22, 8'h33});
    expect_jump(24'h332211, 1'b1, 1'b1);
    run('{8'h40, 8'hc3, 8'hcd, 8'hab});
    expect_jump(24'h00abcd, 1'b0, 1'b1);
  endtask
  task automatic t_pointer();
    run('{8'he9});
    expect_jump(24'h001b2c, 1'b0, 1'b1);
    @(posedge mclk);
    ptr <= 24'hf0e1d2;
    run('{8'h52, 8'he9});
    expect_jump(24'h00e1d2, 1'b0, 1'b1);
    run('{8'h49, 8'he9});
    expect_jump(24'hf0e1d2, 1'b1, 1'b1);
    run('{8'he9});
    expect_jump(24'hf0e1d2, 1'b1, 1'b1);
    run('{8'h52, 8'he9});
    expect_jump(24'h00e1d2, 1'b0, 1'b1);
  endtask
  task automatic t_index();
    run('{8'hdd, 8'he9});
    expect_jump(24'h004d5e, 1'b0, 1'b1);
    run('{8'hfd, 8'he9});
    expect_jump(24'h00d2e3, 1'b0, 1'b1);
    run('{8'h5b, 8'hdd, 8'he9});
    expect_jump(24'h3c4d5e, 1'b1, 1'b1);
    run('{8'hfd, 8'he9});
    expect_jump(24'hc1d2e3, 1'b1, 1'b1);
    run('{8'h40, 8'hfd, 8'he9});
    expect_jump(24'h00d2e3, 1'b0, 1'b1);
  endtask
  // negative displacements on the conditional forms, so a dropped sign extension shows
  task automatic t_relative();
    logic [7:0] d;
    logic       fb;
    for (int i = 0; i < 4; i++) begin
      for (int t = 0; t < 2; t++) begin
        d = 8'h80 + 8'(i * 2 + t);
        fb = i[0] ? t[0] : ~t[0];
        @(posedge mclk);
        flags <= (i < 2) ? {1'b0, fb, 6'h00} : {7'h00, fb};
        run('{8'h20 + 8'(i * 8), d});
        expect_jump({8'h00, cur[15:0] + 16'h2 + (t[0] ? {{8{d[7]}}, d} : 16'h0)}, 1'b0, t[0]);
      end
    end
    run('{8'h18, 8'h7f});
    expect_jump({8'h00, cur[15:0] + 16'h81}, 1'b0, 1'b1);
    run('{8'h5b, 8'hc3, 8'hfe, 8'hff, 8'h12});
    expect_jump(24'h12fffe, 1'b1, 1'b1);
    run('{8'h18, 8'h03});
    expect_jump(24'h130003, 1'b1, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // about 120 cycles are needed; far more means a hang
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    flags = 8'h00;
    ptr = 24'h8a1b2c;
    idx_x = 24'h3c4d5e;
    idx_y = 24'hc1d2e3;
    page = 8'h5a;
    cur = 24'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    check("pc", pc, 24'h0);
    check("wide", {23'h0, wide}, 24'h0);
    t_absolute();
    t_pointer();
    t_index();
    t_relative();
    complete_run();
  end
endmodule
`default_nettype wire

// ### bench/jbp_fetch_model.sv
// Purpose: byte-wide instruction fetch stream feeding the jump block
// Assumes: one byte per cycle, taken on the rising edge with valid high
// Notes:   driven just after an edge and held until the sampling edge
`timescale 1ns/1ps
`default_nettype none
module jbp_fetch_model (
  input  wire logic       clk_i,
  output logic            valid_o,
  output logic [7:0]      byte_o
);
  initial begin
    valid_o = 1'b0;
    byte_o  = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////
  // streams built by the bench never put mixed suffixes on the absolute jump
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    valid_o <= 1'b1;
    byte_o  <= b;
  endtask
  // released line shows the inverse, so a stale byte cannot pass for a real one
  task automatic rest();
    @(posedge clk_i);
    valid_o <= 1'b0;
    byte_o  <= ~byte_o;
  endtask
endmodule
`default_nettype wire

// ### src/jbp_cfg.svh
// Purpose: constants for the jump and program counter update block
// Assumes: byte-wide instruction stream, 24-bit addresses
// Notes:   opcodes and suffix prefixes as fetched
`ifndef JBP_CFG_SVH
`define JBP_CFG_SVH
`define JBP_OP_JP_PTR   8'he9
`define JBP_OP_JP_ABS   8'hc3
`define JBP_OP_JR       8'h18
`define JBP_OP_JR_NOT_ZERO 8'h20
`define JBP_OP_JR_Z     8'h28
`define JBP_OP_JR_NC    8'h30
`define JBP_OP_JR_C     8'h38
`define JBP_PFX_X       8'hdd
`define JBP_PFX_Y       8'hfd
`define JBP_PFX_SHORT_SHORT 8'h40
`define JBP_PFX_LONG_LONG   8'h5b
`define JBP_PFX_S       8'h52
`define JBP_PFX_L       8'h49
`define JBP_PFX_SHORT_LONG  8'h49
`define JBP_PFX_LONG_SHORT  8'h52
`define JBP_RST_PC      24'h000000
`define JBP_RST_WIDE    1'b0
`define JBP_FLAG_Z      6
`define JBP_FLAG_C      0
`endif

// ### src/jbp_core.sv
// Purpose: decode jump instructions from the fetch byte stream and update pc
// Assumes: one byte per INSTR_VALID_I cycle, register values stable meanwhile
// Notes:   other opcodes are simply stepped over with pc advanced by one
`include "jbp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module jbp_core (
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        INSTR_VALID_I,
  input  wire logic [7:0]  INSTR_BYTE_I,
  input  wire logic [23:0] PTR_PAIR_I,
  input  wire logic [23:0] INDEX_X_I,
  input  wire logic [23:0] INDEX_Y_I,
  input  wire logic [7:0]  MEM_BASE_PAGE_I,
  input  wire logic [7:0]  FLAGS_I,
  output logic      [23:0] PC_O,
  output logic      [23:0] FETCH_ADDR_O,
  output logic             WIDE_MODE_O,
  output logic             JUMP_TAKEN_O,
  output logic             ILLEGAL_SFX_O,
  output logic      [7:0]  FLAGS_O
);
  ////////////////////////////////////////////////////////////////////////
  jbp_pkg::jbp_state_t st_q, st_d;
  jbp_pkg::jbp_sfx_t   sfx_q, sfx_d;
  logic [23:0] pc_q, pc_d, opnd_q, opnd_d, fa_q, fa_d;
  logic        wide_q, wide_d, jt_q, jt_d, ill_q, ill_d, xsel_q, xsel_d, ysel_q, ysel_d;
  logic        mixed_q, mixed_d;
  logic [7:0]  fl_q, fl_d;
  logic [1:0]  kind;
  logic [23:0] src, tgt_pc;
  logic        tgt_wide, do_jump;
  logic [23:0] pc_inc, pc_inc_w;
  logic [7:0]  b;
  ////////////////////////////////////////////////////////////////////////
  assign b        = INSTR_BYTE_I;
  assign pc_inc   = pc_q + 24'h000001;
  assign pc_inc_w = wide_q ? pc_inc : {8'h00, pc_inc[15:0]};
  jbp_target u_tgt (
    .kind_i      (kind),
    .wide_i      (wide_q),
    .long_i      (sfx_q == jbp_pkg::JBP_SFX_LONG),
    .short_i     (sfx_q == jbp_pkg::JBP_SFX_SHORT),
    .src_i       (src),
    .next_pc_i   (pc_inc[15:0]),
    .next_pc_w_i (pc_inc_w),
    .disp_i      (b),
    .pc_o        (tgt_pc),
    .wide_o      (tgt_wide)
  );
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d    = st_q;
    sfx_d   = sfx_q;
    pc_d    = pc_q;
    opnd_d  = opnd_q;
    wide_d  = wide_q;
    jt_d    = 1'b0;
    ill_d   = 1'b0;
    xsel_d  = xsel_q;
    ysel_d  = ysel_q;
    mixed_d = mixed_q;
    fl_d    = FLAGS_I; // flags pass through untouched by every jump
    kind    = 2'd2;
    src     = PTR_PAIR_I;
    do_jump = 1'b0;
    if (xsel_q) begin
      src = INDEX_X_I;
    end else if (ysel_q) begin
      src = INDEX_Y_I;
    end
    if (INSTR_VALID_I) begin
      pc_d = pc_inc_w;
      case (st_q)
        jbp_pkg::JBP_IDLE, jbp_pkg::JBP_OPC: begin
          st_d = jbp_pkg::JBP_OPC;
          case (b)
            `JBP_PFX_SHORT_SHORT: begin
              sfx_d = jbp_pkg::JBP_SFX_SHORT;
            end
            `JBP_PFX_LONG_LONG: begin
              sfx_d = jbp_pkg::JBP_SFX_LONG;
            end
            // short and long single suffixes share codes with the mixed forms
            `JBP_PFX_S: begin
              sfx_d   = jbp_pkg::JBP_SFX_SHORT;
              mixed_d = 1'b1;
            end
            `JBP_PFX_L: begin
              sfx_d   = jbp_pkg::JBP_SFX_LONG;
              mixed_d = 1'b1;
            end
            `JBP_PFX_X: begin
              xsel_d = 1'b1;
              ysel_d = 1'b0;
            end
            `JBP_PFX_Y: begin
              ysel_d = 1'b1;
              xsel_d = 1'b0;
            end
            `JBP_OP_JP_PTR: begin
              kind    = 2'd2;
              do_jump = 1'b1;
            end
            `JBP_OP_JP_ABS: begin
              st_d   = jbp_pkg::JBP_OPND0;
              opnd_d = 24'h000000;
            end
            `JBP_OP_JR, `JBP_OP_JR_NOT_ZERO, `JBP_OP_JR_Z, `JBP_OP_JR_NC, `JBP_OP_JR_C: begin
              st_d   = jbp_pkg::JBP_OPND2;
              opnd_d = {16'h0000, b};
            end
            default: begin
              sfx_d   = jbp_pkg::JBP_SFX_NONE;
              mixed_d = 1'b0;
              xsel_d  = 1'b0;
              ysel_d  = 1'b0;
            end
          endcase
          if (do_jump) begin
            pc_d    = tgt_pc;
            wide_d  = tgt_wide;
            jt_d    = 1'b1;
            sfx_d   = jbp_pkg::JBP_SFX_NONE;
            mixed_d = 1'b0;
            xsel_d  = 1'b0;
            ysel_d  = 1'b0;
          end
        end
        jbp_pkg::JBP_OPND0: begin
          opnd_d = {16'h0000, b}; // low byte first
          st_d   = jbp_pkg::JBP_OPND1;
        end
        jbp_pkg::JBP_OPND1: begin
          opnd_d = {8'h00, b, opnd_q[7:0]};
          // two-byte target unless the long form is in force
          if ((sfx_q == jbp_pkg::JBP_SFX_LONG) || (wide_q && sfx_q != jbp_pkg::JBP_SFX_SHORT)) begin
            st_d = jbp_pkg::JBP_OPND2;
            opnd_d = {8'h80, b, opnd_q[7:0]};
          end else begin
            kind    = 2'd0;
            src     = {8'h00, b, opnd_q[7:0]};
            do_jump = 1'b1;
          end
        end
        jbp_pkg::JBP_OPND2: begin
          if (opnd_q[23]) begin
            kind    = 2'd0;
            src     = {b, opnd_q[15:0]};
            do_jump = 1'b1;
          end else begin
            kind = 2'd1;
            case (opnd_q[7:0])
              `JBP_OP_JR_NOT_ZERO: do_jump = ~FLAGS_I[`JBP_FLAG_Z];
              `JBP_OP_JR_Z:  do_jump = FLAGS_I[`JBP_FLAG_Z];
              `JBP_OP_JR_NC: do_jump = ~FLAGS_I[`JBP_FLAG_C];
              `JBP_OP_JR_C:  do_jump = FLAGS_I[`JBP_FLAG_C];
              default:       do_jump = 1'b1;
            endcase
          end
        end
        default: begin
          st_d = jbp_pkg::JBP_IDLE;
        end
      endcase
      if (st_q == jbp_pkg::JBP_OPND1 || st_q == jbp_pkg::JBP_OPND2) begin
        if (do_jump) begin
          // mixed suffix on an absolute jump is flagged, still executed as decoded
          ill_d  = mixed_q && (kind == 2'd0);
          pc_d   = tgt_pc;
          wide_d = tgt_wide;
          jt_d   = 1'b1;
        end
        if (do_jump || kind == 2'd1) begin
          st_d    = jbp_pkg::JBP_IDLE;
          sfx_d   = jbp_pkg::JBP_SFX_NONE;
          mixed_d = 1'b0;
          xsel_d  = 1'b0;
          ysel_d  = 1'b0;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    // fetch address adds the base page only in compatibility mode
    fa_d = wide_d ? pc_d : {MEM_BASE_PAGE_I, pc_d[15:0]};
  end
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      st_q    <= jbp_pkg::JBP_IDLE;
      sfx_q   <= jbp_pkg::JBP_SFX_NONE;
      pc_q    <= `JBP_RST_PC;
      opnd_q  <= 24'h000000;
      fa_q    <= 24'h000000;
      wide_q  <= `JBP_RST_WIDE;
      jt_q    <= 1'b0;
      ill_q   <= 1'b0;
      xsel_q  <= 1'b0;
      ysel_q  <= 1'b0;
      mixed_q <= 1'b0;
      fl_q    <= 8'h00;
    end else begin
      st_q    <= st_d;
      sfx_q   <= sfx_d;
      pc_q    <= pc_d;
      opnd_q  <= opnd_d;
      fa_q    <= fa_d;
      wide_q  <= wide_d;
      jt_q    <= jt_d;
      ill_q   <= ill_d;
      xsel_q  <= xsel_d;
      ysel_q  <= ysel_d;
      mixed_q <= mixed_d;
      fl_q    <= fl_d;
    end
  end
  assign PC_O          = pc_q;
  assign FETCH_ADDR_O  = fa_q;
  assign WIDE_MODE_O   = wide_q;
  assign JUMP_TAKEN_O  = jt_q;
  assign ILLEGAL_SFX_O = ill_q;
  assign FLAGS_O       = fl_q;
endmodule
`default_nettype wire

// ### src/jbp_pkg.sv
// Purpose: types for the jump and program counter update block
// Assumes: nothing beyond the cfg header
// Notes:   state and suffix encodings left to the tool
package jbp_pkg;
  typedef enum logic [2:0] {
    JBP_IDLE,
    JBP_OPC,
    JBP_OPND0,
    JBP_OPND1,
    JBP_OPND2
  } jbp_state_t;
  typedef enum logic [2:0] {
    JBP_SFX_NONE,
    JBP_SFX_SHORT,
    JBP_SFX_LONG,
    JBP_SFX_BAD
  } jbp_sfx_t;
  typedef enum logic [1:0] {
    JBP_K_ABS,
    JBP_K_REL,
    JBP_K_IND
  } jbp_kind_t;
endpackage

// ### src/jbp_target.sv
// Purpose: compute the new program counter and mode bit for a taken jump
// Assumes: operands already gathered, result registered by the caller
// Notes:   purely combinational, one jump kind at a time
`timescale 1ns/1ps
`default_nettype none
module jbp_target (
  input  wire logic [1:0]  kind_i,
  input  wire logic        wide_i,
  input  wire logic        long_i,
  input  wire logic        short_i,
  input  wire logic [23:0] src_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic [23:0] next_pc_w_i,
  input  wire logic [7:0]  disp_i,
  output logic      [23:0] pc_o,
  output logic             wide_o
);
  logic        wide_n;
  logic [23:0] rel;
  always_comb begin
    // suffix wins over the current mode; without one the mode is kept
    wide_n = long_i ? 1'b1 : (short_i ? 1'b0 : wide_i);
    // relative base is the address after the whole instruction
    rel    = next_pc_w_i + {{16{disp_i[7]}}, disp_i};
    pc_o   = 24'h000000;
    wide_o = wide_i;
    case (kind_i)
      2'd1: begin
        // relative jump keeps the mode; in compatibility mode the page wraps
        pc_o   = wide_i ? rel : {8'h00, rel[15:0]};
        wide_o = wide_i;
      end
      default: begin
        // upper byte is ignored when the result is 16-bit; page is added on fetch
        pc_o   = wide_n ? src_i : {8'h00, src_i[15:0]};
        wide_o = wide_n;
      end
    endcase
  end
  logic unused_ok;
  assign unused_ok = ^next_pc_i;
endmodule
`default_nettype wire
